// File: design/serial_fifo_map.svh
`ifndef SERIAL_FIFO_MAP_SVH
`define SERIAL_FIFO_MAP_SVH

// Depth in bits and margin of the almost flag.
`define SFIFO_DEPTH_DEFAULT   64
`define SFIFO_ALMOST_MARGIN   8

// Register byte offsets on the Avalon-MM slave.
`define SFIFO_STATUS_OFS      4'h0
`define SFIFO_CTRL_OFS        4'h4
`define SFIFO_WR_COUNT_OFS    4'h8
`define SFIFO_RD_COUNT_OFS    4'hc

// Status register bit positions.
`define SFIFO_STAT_IR_BIT     0
`define SFIFO_STAT_OR_BIT     1
`define SFIFO_STAT_HF_BIT     2
`define SFIFO_STAT_AFAE_BIT   3
`define SFIFO_STAT_W          4

// Control register bit positions and reset value.
`define SFIFO_CTRL_WR_GATE    0
`define SFIFO_CTRL_RD_GATE    1
`define SFIFO_CTRL_W          2
`define SFIFO_CTRL_RESET      2'h3

// Reset values of the flags.
`define SFIFO_HF_RESET        1'b0
`define SFIFO_AFAE_RESET      1'b1
`define SFIFO_STAT_RESET      4'h8

`endif

// File: design/serial_fifo_pkg.sv
`default_nettype none

package serial_fifo_pkg;

   // Avalon-MM slave address and data.
   typedef logic [3:0]  bus_addr_t;
   typedef logic [31:0] bus_data_t;
   typedef logic [3:0]  bus_be_t;

   // Register selected by a bus address.
   typedef enum logic [3:0] {
      SEL_STATUS   = 4'h1,
      SEL_CTRL     = 4'h2,
      SEL_WR_COUNT = 4'h4,
      SEL_RD_COUNT = 4'h8
   } reg_sel_t;

   // Bus answer sequencer.
   typedef enum logic [1:0] {
      AV_IDLE   = 2'h1,
      AV_ANSWER = 2'h2
   } av_state_t;

endpackage : serial_fifo_pkg

`default_nettype wire

// File: design/bit_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none

// Joins the storage core to the flag and port logic around it.
interface bit_fifo_if #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 64
);
   localparam int PW = $clog2(DEPTH) + 1;

   logic             wr_valid;
   logic             wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic             rd_valid;
   logic             rd_ready;
   logic [WIDTH-1:0] rd_data;
   logic [PW-1:0]    rd_count;

   modport core (input wr_valid, input wr_data, input rd_ready,
                 output wr_ready, output rd_valid, output rd_data, output rd_count);
   modport user (output wr_valid, output wr_data, output rd_ready,
                 input wr_ready, input rd_valid, input rd_data, input rd_count);
endinterface : bit_fifo_if

`default_nettype wire

// File: design/bit_fifo_core.sv
`timescale 1ns/100ps
`default_nettype none

module bit_fifo_core #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 64
) (
   // Clocks and reset.
   input wire logic write_clock,
   input wire logic read_clock,
   input wire logic rstn,
   // Handshake toward the port logic.
   bit_fifo_if.core port
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wbin_reg;
   logic [PW-1:0]    wgray_reg;
   logic [PW-1:0]    rbin_reg;
   logic [PW-1:0]    rgray_reg;
   logic [PW-1:0]    rgray_s1_reg;
   logic [PW-1:0]    rgray_s2_reg;
   logic [PW-1:0]    rgray_s3_reg;
   logic [PW-1:0]    wgray_s1_reg;
   logic [PW-1:0]    wgray_s2_reg;
   logic [PW-1:0]    wgray_s3_reg;
   logic [PW-1:0]    wbin_next;
   logic [PW-1:0]    rbin_next;
   logic [PW-1:0]    wr_fill;
   logic             push;
   logic             pop;

   // Gray pointers change one bit per step, so a late sample is still a valid pointer.
   function automatic logic [PW-1:0] gray_to_bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray_to_bin

   // Fill as seen by the writer is pessimistic, so full never lies.
   assign wr_fill       = wbin_reg - gray_to_bin(rgray_s3_reg);
   assign port.wr_ready = (wr_fill != PW'(DEPTH));
   assign push          = port.wr_valid & port.wr_ready;
   assign wbin_next     = wbin_reg + PW'(1);

   // Count as seen by the reader includes the bit shown at the output.
   assign port.rd_count = gray_to_bin(wgray_s3_reg) - rbin_reg;
   assign port.rd_valid = (port.rd_count != '0);
   assign port.rd_data  = mem_reg[rbin_reg[AW-1:0]];
   assign pop           = port.rd_valid & port.rd_ready;
   assign rbin_next     = rbin_reg + PW'(1);

   // Storage is written only by an accepted push; it needs no reset.
   always_ff @(posedge write_clock) begin
      if (push) begin
         mem_reg[wbin_reg[AW-1:0]] <= port.wr_data;
      end
   end

   // Write pointer, cleared by reset so that stored bits are discarded.
   always_ff @(posedge write_clock or negedge rstn) begin
      if (!rstn) begin
         wbin_reg  <= '0;
         wgray_reg <= '0;
      end else if (push) begin
         wbin_reg  <= wbin_next;
         wgray_reg <= (wbin_next >> 1) ^ wbin_next;
      end
   end

   // Read pointer advances by one bit on an accepted pop.
   always_ff @(posedge read_clock or negedge rstn) begin
      if (!rstn) begin
         rbin_reg  <= '0;
         rgray_reg <= '0;
      end else if (pop) begin
         rbin_reg  <= rbin_next;
         rgray_reg <= (rbin_next >> 1) ^ rbin_next;
      end
   end

   // Read pointer crosses into the write domain through three stages.
   always_ff @(posedge write_clock or negedge rstn) begin
      if (!rstn) begin
         rgray_s1_reg <= '0;
         rgray_s2_reg <= '0;
         rgray_s3_reg <= '0;
      end else begin
         rgray_s1_reg <= rgray_reg;
         rgray_s2_reg <= rgray_s1_reg;
         rgray_s3_reg <= rgray_s2_reg;
      end
   end

   // Write pointer crosses into the read domain through three stages.
   always_ff @(posedge read_clock or negedge rstn) begin
      if (!rstn) begin
         wgray_s1_reg <= '0;
         wgray_s2_reg <= '0;
         wgray_s3_reg <= '0;
      end else begin
         wgray_s1_reg <= wgray_reg;
         wgray_s2_reg <= wgray_s1_reg;
         wgray_s3_reg <= wgray_s2_reg;
      end
   end

endmodule : bit_fifo_core

`default_nettype wire

// File: design/dual_clock_serial_bit_fifo.sv
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fifo_map.svh"

// What this block does
// - A bit leaves the store on a read-clock rise only when read enable and output ready are high.
// - The output-ready flag changes only on read-clock rises.
// - During reset half full, input ready and output ready are low, the almost flag high, data lost.
// - A bit is stored on a write-clock rise only when write enable and input ready are high.
// - The input-ready flag changes only on write-clock rises.
// - Input ready rises on the second write-clock rise after reset and low means full.
// - A first bit into an empty store shows, with output ready, on the third read rise.
// - Half full is high while stored bits, not counting the shown bit, reach half the depth.
// - The almost flag is high with eight or fewer bits stored or places free.
module dual_clock_serial_bit_fifo #(
   parameter int DEPTH = `SFIFO_DEPTH_DEFAULT
) (
   // Register bus clock and reset.
   input  wire logic                       clk,
   input  wire logic                       rstn,
   // Avalon-MM slave.
   input  wire serial_fifo_pkg::bus_addr_t address,
   input  wire logic                       read,
   input  wire logic                       write,
   input  wire serial_fifo_pkg::bus_data_t writedata,
   input  wire serial_fifo_pkg::bus_be_t   byteenable,
   output logic [31:0]                     readdata,
   output logic                            waitrequest,
   // Write side.
   input  wire logic                       write_clock,
   input  wire logic                       write_enable,
   input  wire logic                       data_in,
   output logic                            input_ready_flag,
   // Read side.
   input  wire logic                       read_clock,
   input  wire logic                       read_enable,
   output logic                            data_out,
   output logic                            output_ready_flag,
   output logic                            half_full_flag,
   output logic                            almost_full_empty_flag
);
   import serial_fifo_pkg::*;

   localparam int PW = $clog2(DEPTH) + 1;
   localparam int SW = `SFIFO_STAT_W;

   bit_fifo_if #(.WIDTH(1), .DEPTH(DEPTH)) fifo_port ();

   logic                   ir_arm1_reg;
   logic                   ir_arm2_reg;
   logic [2:0]             wgate_sync_reg;
   logic                   wgate_reg;
   logic [2:0]             rgate_sync_reg;
   logic                   rgate_reg;
   logic                   wr_toggle_reg;
   logic                   rd_toggle_reg;
   logic                   half_full_reg;
   logic                   almost_reg;
   logic [PW-1:0]          stored;
   logic [PW-1:0]          free_places;
   logic [SW-1:0]          stat_raw;
   logic [SW-1:0]          stat_s1_reg;
   logic [SW-1:0]          stat_s2_reg;
   logic [SW-1:0]          stat_s3_reg;
   logic [SW-1:0]          stat_reg;
   logic [2:0]             wtog_sync_reg;
   logic [2:0]             rtog_sync_reg;
   logic                   wr_event;
   logic                   rd_event;
   logic [31:0]            wr_count_reg;
   logic [31:0]            rd_count_reg;
   logic [`SFIFO_CTRL_W-1:0] ctrl_reg;
   logic [31:0]            readdata_reg;
   av_state_t              state_reg;
   av_state_t              state_next;
   logic                   req;
   logic                   write_fire;
   reg_sel_t               sel;

   // Decode shared by both bus paths.
   function automatic reg_sel_t decode(input bus_addr_t a);
      case (a)
         `SFIFO_STATUS_OFS:   decode = SEL_STATUS;
         `SFIFO_CTRL_OFS:     decode = SEL_CTRL;
         `SFIFO_WR_COUNT_OFS: decode = SEL_WR_COUNT;
         `SFIFO_RD_COUNT_OFS: decode = SEL_RD_COUNT;
         default:             decode = reg_sel_t'(4'h0);
      endcase
   endfunction : decode

   // Storage core with gray pointers.
   bit_fifo_core #(.WIDTH(1), .DEPTH(DEPTH)) core (
      .write_clock (write_clock),
      .read_clock  (read_clock),
      .rstn        (rstn),
      .port        (fifo_port.core)
   );

   // ---- Write clock domain ----

   // Input ready waits two write rises after reset.
   always_ff @(posedge write_clock or negedge rstn) begin
      if (!rstn) begin
         ir_arm1_reg <= 1'b0;
         ir_arm2_reg <= 1'b0;
      end else begin
         ir_arm1_reg <= 1'b1;
         ir_arm2_reg <= ir_arm1_reg;
      end
   end

   // Write-domain flops only, so it moves on write rises.
   assign input_ready_flag   = ir_arm2_reg & fifo_port.wr_ready;
   // A write is taken only with enable and ready both high.
   assign fifo_port.wr_valid = write_enable & input_ready_flag & wgate_reg;
   assign fifo_port.wr_data  = data_in;

   // Software write gate; taken once stages two and three agree.
   always_ff @(posedge write_clock or negedge rstn) begin
      if (!rstn) begin
         wgate_sync_reg <= {3{1'(`SFIFO_CTRL_RESET >> `SFIFO_CTRL_WR_GATE)}};
         wgate_reg      <= 1'b1;
      end else begin
         wgate_sync_reg <= {wgate_sync_reg[1:0], ctrl_reg[`SFIFO_CTRL_WR_GATE]};
         if (wgate_sync_reg[1] == wgate_sync_reg[2]) begin
            wgate_reg <= wgate_sync_reg[2];
         end
      end
   end

   // Toggle per accepted write; the bus side counts the edges.
   always_ff @(posedge write_clock or negedge rstn) begin
      if (!rstn) begin
         wr_toggle_reg <= 1'b0;
      end else if (fifo_port.wr_valid & fifo_port.wr_ready) begin
         wr_toggle_reg <= ~wr_toggle_reg;
      end
   end

   // ---- Read clock domain ----

   // Output ready comes from read-domain flops only; data is the stored bit at the read pointer.
   assign output_ready_flag  = fifo_port.rd_valid;
   assign data_out           = fifo_port.rd_data;
   // A bit is removed only with enable and ready both high.
   assign fifo_port.rd_ready = read_enable & output_ready_flag & rgate_reg;

   // The shown bit is not stored.
   assign stored      = fifo_port.rd_count - (output_ready_flag ? PW'(1) : PW'(0));
   assign free_places = PW'(DEPTH) - fifo_port.rd_count;

   // Level flags trail the count by one read rise.
   always_ff @(posedge read_clock or negedge rstn) begin
      if (!rstn) begin
         half_full_reg <= `SFIFO_HF_RESET;
         almost_reg    <= `SFIFO_AFAE_RESET;
      end else begin
         half_full_reg <= (stored >= PW'(DEPTH / 2));
         almost_reg    <= (stored <= PW'(`SFIFO_ALMOST_MARGIN)) |
                          (free_places <= PW'(`SFIFO_ALMOST_MARGIN));
      end
   end

   assign half_full_flag         = half_full_reg;
   assign almost_full_empty_flag = almost_reg;

   // Read gate from software, filtered like the write gate.
   always_ff @(posedge read_clock or negedge rstn) begin
      if (!rstn) begin
         rgate_sync_reg <= {3{1'(`SFIFO_CTRL_RESET >> `SFIFO_CTRL_RD_GATE)}};
         rgate_reg      <= 1'b1;
      end else begin
         rgate_sync_reg <= {rgate_sync_reg[1:0], ctrl_reg[`SFIFO_CTRL_RD_GATE]};
         if (rgate_sync_reg[1] == rgate_sync_reg[2]) begin
            rgate_reg <= rgate_sync_reg[2];
         end
      end
   end

   // Toggle per accepted read.
   always_ff @(posedge read_clock or negedge rstn) begin
      if (!rstn) begin
         rd_toggle_reg <= 1'b0;
      end else if (fifo_port.rd_valid & fifo_port.rd_ready) begin
         rd_toggle_reg <= ~rd_toggle_reg;
      end
   end

   // ---- Bus clock domain ----

   always_comb begin
      stat_raw                        = '0;
      stat_raw[`SFIFO_STAT_IR_BIT]    = input_ready_flag;
      stat_raw[`SFIFO_STAT_OR_BIT]    = output_ready_flag;
      stat_raw[`SFIFO_STAT_HF_BIT]    = half_full_flag;
      stat_raw[`SFIFO_STAT_AFAE_BIT]  = almost_full_empty_flag;
   end

   // Flags cross one by one; a read may mix nearby moments.
   generate
      for (genvar g = 0; g < SW; g++) begin : g_stat_sync
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               stat_s1_reg[g] <= 1'(`SFIFO_STAT_RESET >> g);
               stat_s2_reg[g] <= 1'(`SFIFO_STAT_RESET >> g);
               stat_s3_reg[g] <= 1'(`SFIFO_STAT_RESET >> g);
               stat_reg[g]    <= 1'(`SFIFO_STAT_RESET >> g);
            end else begin
               stat_s1_reg[g] <= stat_raw[g];
               stat_s2_reg[g] <= stat_s1_reg[g];
               stat_s3_reg[g] <= stat_s2_reg[g];
               if (stat_s2_reg[g] == stat_s3_reg[g]) begin
                  stat_reg[g] <= stat_s3_reg[g];
               end
            end
         end
      end
   endgenerate

   // Event toggles cross in three stages; each count is exact while its port clock
   // is slower than half the bus clock.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wtog_sync_reg <= 3'h0;
         rtog_sync_reg <= 3'h0;
      end else begin
         wtog_sync_reg <= {wtog_sync_reg[1:0], wr_toggle_reg};
         rtog_sync_reg <= {rtog_sync_reg[1:0], rd_toggle_reg};
      end
   end

   assign wr_event = wtog_sync_reg[1] ^ wtog_sync_reg[2];
   assign rd_event = rtog_sync_reg[1] ^ rtog_sync_reg[2];

   // Bus answers one cycle after the request is seen.
   assign req         = read | write;
   assign sel         = decode(address);
   assign waitrequest = req & (state_reg != AV_ANSWER);
   assign write_fire  = write & (state_reg == AV_ANSWER);
   assign readdata    = readdata_reg;

   always_comb begin
      case (state_reg)
         AV_IDLE:   state_next = req ? AV_ANSWER : AV_IDLE;
         AV_ANSWER: state_next = AV_IDLE;
         default:   state_next = AV_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= AV_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Read data is captured in the wait cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readdata_reg <= 32'h0;
      end else if (read & (state_reg == AV_IDLE)) begin
         case (sel)
            SEL_STATUS:   readdata_reg <= {{(32 - SW){1'b0}}, stat_reg};
            SEL_CTRL:     readdata_reg <= {{(32 - `SFIFO_CTRL_W){1'b0}}, ctrl_reg};
            SEL_WR_COUNT: readdata_reg <= wr_count_reg;
            SEL_RD_COUNT: readdata_reg <= rd_count_reg;
            default:      readdata_reg <= 32'h0;
         endcase
      end
   end

   // Control register; the low byte lane carries both gates.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `SFIFO_CTRL_RESET;
      end else if (write_fire & (sel == SEL_CTRL) & byteenable[0]) begin
         ctrl_reg <= writedata[`SFIFO_CTRL_W-1:0];
      end
   end

   // A write to a counter clears it whatever the data; an event in the same cycle still counts.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_count_reg <= 32'h0;
      end else if (write_fire & (sel == SEL_WR_COUNT)) begin
         wr_count_reg <= {31'h0, wr_event};
      end else if (wr_event) begin
         wr_count_reg <= wr_count_reg + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_count_reg <= 32'h0;
      end else if (write_fire & (sel == SEL_RD_COUNT)) begin
         rd_count_reg <= {31'h0, rd_event};
      end else if (rd_event) begin
         rd_count_reg <= rd_count_reg + 32'h1;
      end
   end

endmodule : dual_clock_serial_bit_fifo

`default_nettype wire

// File: dv/serial_fifo_checker.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the flag and bus ports of the bit store from outside.
module serial_fifo_checker (
   // Bus side.
   input wire logic clk,
   input wire logic rstn,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // Write side.
   input wire logic write_clock,
   input wire logic input_ready_flag,
   // Read side.
   input wire logic read_clock,
   input wire logic read_enable,
   input wire logic data_out,
   input wire logic output_ready_flag,
   input wire logic half_full_flag,
   input wire logic almost_full_empty_flag
);
   logic ir_snap;
   logic or_snap;

   // Flags must hold from a fall to the next rise of their clock.
   always_ff @(negedge write_clock) ir_snap <= input_ready_flag;
   always_ff @(negedge read_clock) or_snap <= output_ready_flag;

   // Input ready low for two write rises after release.
   sequence ir_held_low;
      !input_ready_flag [*2];
   endsequence

   reset_flags_a: assert property (@(posedge clk) !rstn |-> !input_ready_flag
      && !output_ready_flag && !half_full_flag && almost_full_empty_flag)
      else $error("flags wrong during reset");
   ir_wakeup_a: assert property (@(posedge write_clock) disable iff (!rstn)
      $rose(rstn) |-> ir_held_low ##1 input_ready_flag) else $error("input ready wakeup wrong");
   ir_own_edge_a: assert property (@(posedge clk) disable iff (!rstn)
      !write_clock |-> input_ready_flag == ir_snap) else $error("input ready moved off edge");
   or_own_edge_a: assert property (@(posedge clk) disable iff (!rstn)
      !read_clock |-> output_ready_flag == or_snap) else $error("output ready moved off edge");
   hold_no_read_a: assert property (@(posedge read_clock) disable iff (!rstn)
      output_ready_flag && !read_enable |=> output_ready_flag && $stable(data_out))
      else $error("data left without a read");
   hf_has_data_a: assert property (@(posedge read_clock) disable iff (!rstn)
      half_full_flag |-> output_ready_flag) else $error("half full while empty");
   bus_answer_a: assert property (@(posedge clk) disable iff (!rstn)
      (read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
   bus_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      !(read || write) |-> !waitrequest) else $error("wait raised while idle");
endmodule : serial_fifo_checker

bind dual_clock_serial_bit_fifo serial_fifo_checker serial_fifo_checker_i (
   .clk, .rstn, .read, .write, .waitrequest, .write_clock, .input_ready_flag,
   .read_clock, .read_enable, .data_out, .output_ready_flag, .half_full_flag,
   .almost_full_empty_flag);

`default_nettype wire

// File: dv/serial_partner.sv
`timescale 1ns/100ps
`default_nettype none

// Serial source and consumer facing the bit store.
module serial_partner (
   // Clocks and reset.
   input  wire logic        write_clock,
   input  wire logic        read_clock,
   input  wire logic        rstn,
   // From the store.
   input  wire logic        input_ready_flag,
   input  wire logic        output_ready_flag,
   input  wire logic        data_out,
   // Toward the store.
   output logic             write_enable,
   output logic             data_in,
   output logic             read_enable,
   // Quotas and progress.
   input  wire logic [31:0] wr_quota,
   input  wire logic [31:0] rd_quota,
   output logic [31:0]      wr_sent,
   output logic [31:0]      rd_got,
   output logic [255:0]     got_bits
);
   logic [31:0] wr_next;
   logic [31:0] rd_next;

   // Source bit k, mixed so runs stay short.
   function automatic logic pat(input logic [31:0] k);
      return k[0] ^ k[2] ^ k[5];
   endfunction : pat

   // A transfer needs enable and flag high at the rise.
   assign wr_next = wr_sent + {31'h0, write_enable & input_ready_flag};
   assign rd_next = rd_got + {31'h0, read_enable & output_ready_flag};

   // Nothing offered before reset; idle data toggles so stale bits show.
   always_ff @(posedge write_clock or negedge rstn) begin
      if (!rstn) begin
         wr_sent      <= 32'h0;
         write_enable <= 1'b0;
         data_in      <= 1'b0;
      end else begin
         wr_sent      <= wr_next;
         write_enable <= wr_next < wr_quota;
         data_in      <= (wr_next < wr_quota) ? pat(wr_next) : ~data_in;
      end
   end

   // The consumer keeps each bit that it takes.
   always_ff @(posedge read_clock or negedge rstn) begin
      if (!rstn) begin
         rd_got      <= 32'h0;
         read_enable <= 1'b0;
         got_bits    <= '0;
      end else begin
         if (read_enable && output_ready_flag) begin
            got_bits[rd_got[7:0]] <= data_out;
         end
         rd_got      <= rd_next;
         read_enable <= rd_next < rd_quota;
      end
   end
endmodule : serial_partner

`default_nettype wire

// File: dv/dual_clock_serial_bit_fifo_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "serial_fifo_map.svh"

module dual_clock_serial_bit_fifo_test;
   import serial_fifo_pkg::*;
   logic clk = 0, rstn = 1, read = 0, write = 0, write_clock = 0, read_clock = 0;
   logic write_enable, data_in, read_enable, data_out, input_ready_flag, output_ready_flag;
   logic half_full_flag, almost_full_empty_flag, waitrequest;
   bus_addr_t address = 4'h0;
   bus_data_t writedata = 32'h0;
   bus_data_t rdata;
   logic [31:0] readdata, wr_sent, rd_got;
   logic [31:0] wr_quota = 32'h0, rd_quota = 32'h0;
   logic [255:0] got_bits;
   int bad_count = 0, num_checks = 0;

   // Three unrelated clocks; port clocks stay below half the bus rate.
   always #2 clk = ~clk;
   always #4.5 write_clock = ~write_clock;
   always #5 read_clock = ~read_clock;

   dual_clock_serial_bit_fifo #(.DEPTH(64)) dual_clock_serial_bit_fifo_i (
      .clk, .rstn, .address, .read, .write, .writedata, .byteenable(4'hf), .readdata,
      .waitrequest, .write_clock, .write_enable, .data_in, .input_ready_flag, .read_clock,
      .read_enable, .data_out, .output_ready_flag, .half_full_flag, .almost_full_empty_flag);

   serial_partner serial_partner_i (
      .write_clock, .read_clock, .rstn, .input_ready_flag, .output_ready_flag, .data_out,
      .write_enable, .data_in, .read_enable, .wr_quota, .rd_quota, .wr_sent, .rd_got,
      .got_bits);

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic time_out();
      bad_count++;
      $display("unexpected hang at %0t", $time);
      wrap_up();
   endtask : time_out

   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask : chk1

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32

   // One request, held until waitrequest is low at a rise.
   task automatic bus_xfer(input logic wr, input bus_addr_t a, input bus_data_t wd);
      int i;
      @(posedge clk);
      address   <= a;
      writedata <= wd;
      read      <= ~wr;
      write     <= wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      rdata = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (i == 20) time_out();
   endtask : bus_xfer

   // Bounded wait for a source or consumer count.
   task automatic wait_for(input logic rd_side, input logic [31:0] n);
      int i;
      for (i = 0; i < 5000; i++) begin
         @(posedge clk);
         if ((rd_side ? rd_got : wr_sent) === n) break;
      end
      if (i == 5000) time_out();
   endtask : wait_for

   task automatic rd_edges(input int n);
      repeat (n) @(posedge read_clock);
      @(negedge read_clock);
   endtask : rd_edges

   task automatic after_reset();
      @(posedge write_clock);
      @(negedge write_clock);
      chk1(input_ready_flag, 1'b0);
      repeat (2) @(posedge write_clock);
      @(negedge write_clock);
      chk1(input_ready_flag, 1'b1);
      bus_xfer(1'b0, `SFIFO_STATUS_OFS, 32'h0);
      chk32(rdata, 32'h9);
      bus_xfer(1'b1, `SFIFO_CTRL_OFS, 32'h1);
      bus_xfer(1'b0, `SFIFO_CTRL_OFS, 32'h0);
      chk32(rdata, 32'h1);
      bus_xfer(1'b1, `SFIFO_CTRL_OFS, 32'h3);
      bus_xfer(1'b0, 4'h6, 32'h0);
      chk32(rdata, 32'h0);
   endtask : after_reset

   // First bit must show on the third read rise.
   task automatic first_bit();
      int i, n;
      @(posedge clk);
      wr_quota <= 1;
      for (i = 0; i < 100; i++) begin
         @(posedge write_clock);
         if (write_enable === 1'b1 && input_ready_flag === 1'b1) break;
      end
      if (i == 100) time_out();
      for (n = 1; n < 8; n++) begin
         @(posedge read_clock);
         @(negedge read_clock);
         if (output_ready_flag === 1'b1) break;
      end
      chk32(n, 32'd3);
      chk1(data_out, serial_partner_i.pat(0));
   endtask : first_bit

   // Fill bit by bit with the consumer stalled, then try to overfill.
   task automatic fill_flags();
      int n;
      for (n = 2; n <= 64; n++) begin
         @(posedge clk);
         wr_quota <= n;
         wait_for(1'b0, n);
         rd_edges(8);
         chk1(half_full_flag, (n - 1) >= 32);
         chk1(almost_full_empty_flag, (n - 1) <= 8 || (64 - n) <= 8);
      end
      @(posedge clk);
      wr_quota <= 70;
      repeat (20) @(posedge write_clock);
      chk32(wr_sent, 32'd64);
      chk1(input_ready_flag, 1'b0);
      @(posedge clk);
      wr_quota <= 64;
   endtask : fill_flags

   task automatic drain_all();
      int k;
      @(posedge clk);
      rd_quota <= 64;
      wait_for(1'b1, 64);
      rd_edges(8);
      for (k = 0; k < 64; k++) chk1(got_bits[k], serial_partner_i.pat(k));
      chk1(output_ready_flag, 1'b0);
      chk1(almost_full_empty_flag, 1'b1);
      bus_xfer(1'b0, `SFIFO_WR_COUNT_OFS, 32'h0);
      chk32(rdata, 32'd64);
      bus_xfer(1'b0, `SFIFO_RD_COUNT_OFS, 32'h0);
      chk32(rdata, 32'd64);
   endtask : drain_all

   // Both sides run at once across the two unrelated clocks.
   task automatic stream();
      int k;
      @(posedge clk);
      wr_quota <= 164;
      rd_quota <= 164;
      wait_for(1'b1, 164);
      for (k = 64; k < 164; k++) chk1(got_bits[k], serial_partner_i.pat(k));
   endtask : stream

   // A reset with bits stored must discard them.
   task automatic mid_reset();
      @(posedge clk);
      wr_quota <= 174;
      wait_for(1'b0, 174);
      @(posedge clk);
      rstn     <= 1'b0;
      wr_quota <= 0;
      rd_quota <= 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd_edges(20);
      chk1(output_ready_flag, 1'b0);
      chk1(half_full_flag, 1'b0);
      chk1(almost_full_empty_flag, 1'b1);
   endtask : mid_reset

   // Reset falls at time zero so every flop sees an edge, before any transfer.
   initial begin
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      after_reset();
      first_bit();
      fill_flags();
      drain_all();
      stream();
      mid_reset();
      wrap_up();
   end
endmodule : dual_clock_serial_bit_fifo_test

`default_nettype wire
